/* File: hdl/edpc_params.svh */
`ifndef EDPC_PARAMS_SVH
`define EDPC_PARAMS_SVH
// Register location in the management space
`define EDPC_REG_ADDR 5'h1D
// Field positions
`define EDPC_BIT_ENABLE 15
`define EDPC_BIT_AUTO_WAKE 14
`define EDPC_BIT_AUTO_SLEEP 13
`define EDPC_BIT_MANUAL 12
`define EDPC_BIT_BURST_DIS 11
`define EDPC_BIT_PWR_STATE 10
`define EDPC_BIT_ERR_MET 9
`define EDPC_BIT_DATA_MET 8
`define EDPC_ERR_HI 7
`define EDPC_ERR_LO 4
`define EDPC_DATA_HI 3
`define EDPC_DATA_LO 0
// Reset values
`define EDPC_RST_ENABLE 1'h0
`define EDPC_RST_AUTO_WAKE 1'h1
`define EDPC_RST_AUTO_SLEEP 1'h1
`define EDPC_RST_BURST_DIS 1'h0
`define EDPC_RST_ERR_THR 4'h1
`define EDPC_RST_DATA_THR 4'h1
// Timing: idle time before counters reset, and clock rate
`define EDPC_IDLE_MS 2000
`define EDPC_CLK_KHZ 20000
`define EDPC_IDLE_CYCLES (`EDPC_IDLE_MS * `EDPC_CLK_KHZ)
// Pulses per burst
`define EDPC_BURST_LEN 4
`endif

/* File: hdl/edpc_pkg.sv */
package edpc_pkg;
    // Register access request from the management port
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [4:0] addr;
        logic [15:0] wrData;
    } edpc_req_t;
    // Raw events from the analog energy sense front end
    typedef struct packed {
        logic dataEvent;
        logic errEvent;
        logic noEnergy;
    } edpc_sense_t;
    typedef enum logic [1:0] {
        EDPC_DOWN,
        EDPC_UP
    } edpc_pwr_t;
endpackage

/* File: hdl/energy_detect_power_control.sv */
`timescale 1ns/100ps
`default_nettype none
`include "edpc_params.svh"
module energy_detect_power_control #(
    parameter int IDLE_CYCLES = `EDPC_IDLE_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Management register access, same clock domain
    input wire edpc_pkg::edpc_req_t regReq,
    output logic [15:0] rdData,
    // Energy sense events from the line, asynchronous
    input wire edpc_pkg::edpc_sense_t senseIn,
    // Line driver control
    output logic lineDriverOn,
    output logic pulseOut
);
    import edpc_pkg::*;

    localparam int CW = $clog2(IDLE_CYCLES + 1);

    // Two-stage synchronisers for the sense inputs
    edpc_sense_t syncA, syncB, syncPrev;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            syncA <= '0;
            syncB <= '0;
            syncPrev <= '0;
        end else begin
            syncA <= senseIn;
            syncB <= syncA;
            syncPrev <= syncB;
        end
    end
    // Rising edges taken from the second stage only
    logic dataEv, errEv, noEnergy;
    assign dataEv = syncB.dataEvent & ~syncPrev.dataEvent;
    assign errEv = syncB.errEvent & ~syncPrev.errEvent;
    assign noEnergy = syncB.noEnergy;

    // Register state
    logic enable, autoWake, autoSleep, burstDis, errMet, dataMet;
    logic [3:0] errThr, dataThr;
    logic next_enable, next_autoWake, next_autoSleep, next_burstDis;
    logic next_errMet, next_dataMet;
    logic [3:0] next_errThr, next_dataThr;
    // Power state and counters
    edpc_pwr_t pwr, next_pwr;
    logic [3:0] dataCnt, errCnt, next_dataCnt, next_errCnt;
    logic [CW-1:0] idleCnt, next_idleCnt;
    logic [2:0] pulsesLeft, next_pulsesLeft;
    logic pulse, next_pulse;

    logic hit, wr, rd, manual, dataReach, errReach, idleExpired;
    assign hit = (regReq.addr == `EDPC_REG_ADDR);
    assign wr = hit & regReq.wrEn;
    assign rd = hit & regReq.rdEn;
    // Self-clearing: acts in the write cycle only, never stored
    assign manual = wr & regReq.wrData[`EDPC_BIT_MANUAL];
    assign dataReach = dataEv && ({1'b0, dataCnt} + 5'h01 >= {1'b0, dataThr});
    assign errReach = errEv && ({1'b0, errCnt} + 5'h01 >= {1'b0, errThr});
    assign idleExpired = (idleCnt >= CW'(IDLE_CYCLES - 1));

    // Next-state logic for registers, counters and power state
    always_comb begin
        next_enable = enable;
        next_autoWake = autoWake;
        next_autoSleep = autoSleep;
        next_burstDis = burstDis;
        next_errThr = errThr;
        next_dataThr = dataThr;
        if (wr) begin
            next_enable = regReq.wrData[`EDPC_BIT_ENABLE];
            next_autoWake = regReq.wrData[`EDPC_BIT_AUTO_WAKE];
            next_autoSleep = regReq.wrData[`EDPC_BIT_AUTO_SLEEP];
            next_burstDis = regReq.wrData[`EDPC_BIT_BURST_DIS];
            next_errThr = regReq.wrData[`EDPC_ERR_HI:`EDPC_ERR_LO];
            next_dataThr = regReq.wrData[`EDPC_DATA_HI:`EDPC_DATA_LO];
        end
        // Clear on read first, so a same-cycle event still sets the flag
        next_errMet = rd ? 1'b0 : errMet;
        next_dataMet = rd ? 1'b0 : dataMet;
        next_dataCnt = dataCnt;
        next_errCnt = errCnt;
        next_idleCnt = idleCnt;
        next_pwr = pwr;
        if (enable) begin
            // Counting saturates at 4'hF rather than wrapping past it
            if (dataEv && dataCnt != 4'hF) begin
                next_dataCnt = dataCnt + 4'h1;
            end
            if (errEv && errCnt != 4'hF) begin
                next_errCnt = errCnt + 4'h1;
            end
            if (errReach) begin
                next_errMet = 1'b1;
            end
            if (dataReach) begin
                next_dataMet = 1'b1;
            end
            // Idle timer restarts on any data event
            if (dataEv) begin
                next_idleCnt = '0;
            end else if (idleExpired) begin
                next_idleCnt = '0;
                next_dataCnt = 4'h0;
                next_errCnt = 4'h0;
            end else begin
                next_idleCnt = idleCnt + CW'(1);
            end
            // Manual request beats thresholds and timers
            if (manual) begin
                next_pwr = (pwr == EDPC_UP) ? EDPC_DOWN : EDPC_UP;
            end else if (pwr == EDPC_DOWN && autoWake && dataReach) begin
                next_pwr = EDPC_UP;
            end else if (pwr == EDPC_UP && autoSleep && noEnergy) begin
                next_pwr = EDPC_DOWN;
            end
        end else begin
            // Disabled: driver forced up, counters hold, idle timer kept at zero
            next_pwr = EDPC_UP;
            next_idleCnt = '0;
        end
    end

    // Burst of pulses each time the driver goes up while enabled; one pulse per two cycles
    always_comb begin
        next_pulsesLeft = pulsesLeft;
        next_pulse = 1'b0;
        if (enable && pwr == EDPC_DOWN && next_pwr == EDPC_UP) begin
            next_pulsesLeft = burstDis ? 3'h1 : 3'(`EDPC_BURST_LEN);
        end else if (pulsesLeft != 3'h0 && !pulse) begin
            next_pulse = 1'b1;
            next_pulsesLeft = pulsesLeft - 3'h1;
        end
    end

    // Register all state
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            enable <= `EDPC_RST_ENABLE;
            autoWake <= `EDPC_RST_AUTO_WAKE;
            autoSleep <= `EDPC_RST_AUTO_SLEEP;
            burstDis <= `EDPC_RST_BURST_DIS;
            errThr <= `EDPC_RST_ERR_THR;
            dataThr <= `EDPC_RST_DATA_THR;
            errMet <= 1'b0;
            dataMet <= 1'b0;
            dataCnt <= 4'h0;
            errCnt <= 4'h0;
            idleCnt <= '0;
            pwr <= EDPC_UP;
            pulsesLeft <= 3'h0;
            pulse <= 1'b0;
        end else begin
            enable <= next_enable;
            autoWake <= next_autoWake;
            autoSleep <= next_autoSleep;
            burstDis <= next_burstDis;
            errThr <= next_errThr;
            dataThr <= next_dataThr;
            errMet <= next_errMet;
            dataMet <= next_dataMet;
            dataCnt <= next_dataCnt;
            errCnt <= next_errCnt;
            idleCnt <= next_idleCnt;
            pwr <= next_pwr;
            pulsesLeft <= next_pulsesLeft;
            pulse <= next_pulse;
        end
    end

    // Read data registered one cycle after the read strobe
    logic [15:0] readWord;
    always_comb begin
        readWord = '0;
        readWord[`EDPC_BIT_ENABLE] = enable;
        readWord[`EDPC_BIT_AUTO_WAKE] = autoWake;
        readWord[`EDPC_BIT_AUTO_SLEEP] = autoSleep;
        readWord[`EDPC_BIT_BURST_DIS] = burstDis;
        readWord[`EDPC_BIT_PWR_STATE] = (pwr == EDPC_UP);
        readWord[`EDPC_BIT_ERR_MET] = errMet;
        readWord[`EDPC_BIT_DATA_MET] = dataMet;
        readWord[`EDPC_ERR_HI:`EDPC_ERR_LO] = errThr;
        readWord[`EDPC_DATA_HI:`EDPC_DATA_LO] = dataThr;
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdData <= 16'h0000;
        end else begin
            rdData <= rd ? readWord : rdData;
        end
    end

    assign lineDriverOn = (pwr == EDPC_UP);
    assign pulseOut = pulse;

    // Checks
    chk_disabled_up: assert property (@(posedge core_clk) disable iff (sys_rst)
        !enable |=> lineDriverOn) else $error("driver off while disabled");
    chk_manual_flip: assert property (@(posedge core_clk) disable iff (sys_rst)
        (enable && manual) |=> (lineDriverOn != $past(lineDriverOn)))
        else $error("manual toggle ignored");
    chk_flag_read: assert property (@(posedge core_clk) disable iff (sys_rst)
        (rd && !dataReach) |=> !dataMet) else $error("data flag not cleared");
    chk_err_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        (enable && errReach) |=> errMet) else $error("error flag missed");
    sequence wakeSeq;
        enable && !lineDriverOn && autoWake && dataReach && !manual;
    endsequence
    chk_auto_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
        wakeSeq |=> lineDriverOn) else $error("auto wake missed");
    chk_auto_sleep: assert property (@(posedge core_clk) disable iff (sys_rst)
        (enable && lineDriverOn && autoSleep && noEnergy && !manual) |=> !lineDriverOn)
        else $error("auto sleep missed");
    // Writes excluded at the wake cycle; the burst length is loaded from the stored burstDis, not the written value
    chk_burst_four: assert property (@(posedge core_clk) disable iff (sys_rst)
        (enable && !lineDriverOn && next_pwr == EDPC_UP && !burstDis && !wr)
        |=> ##1 pulseOut ##2 pulseOut ##2 pulseOut ##2 pulseOut)
        else $error("burst wrong");
    chk_burst_one: assert property (@(posedge core_clk) disable iff (sys_rst)
        (enable && !lineDriverOn && next_pwr == EDPC_UP && burstDis && !wr)
        |=> ##1 pulseOut ##1 !pulseOut[*6])
        else $error("single pulse wrong");
    chk_data_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        (enable && dataReach) |=> dataMet) else $error("data flag missed");
    chk_idle_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        (enable && idleExpired && !dataEv) |=> (dataCnt == 4'h0 && errCnt == 4'h0))
        else $error("counters not reset");
    chk_state_bit: assert property (@(posedge core_clk) disable iff (sys_rst)
        rd |=> rdData[`EDPC_BIT_PWR_STATE] == $past(lineDriverOn))
        else $error("power state bit wrong");
endmodule
`default_nettype wire

/* File: test/edpc_line_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Line side of the block: raw sense events in, wake pulses out
module edpc_line_model (
    // Clock
    input wire logic core_clk,
    // Line interface
    output var edpc_pkg::edpc_sense_t senseIn,
    input wire logic pulseOut
);
    import edpc_pkg::*;
    int pulseCount;
    initial begin
        senseIn = '0;
        pulseCount = 0;
    end
    // Pulses are one cycle wide, so each high cycle is one pulse
    always @(posedge core_clk) begin
        if (pulseOut === 1'b1) begin
            pulseCount++;
        end
    end
    // Levels held 3 cycles so the two-flop synchroniser cannot miss an edge
    task automatic lineEvent(input bit isErr);
        @(negedge core_clk);
        if (isErr) begin
            senseIn.errEvent = 1'b1;
        end else begin
            senseIn.dataEvent = 1'b1;
        end
        repeat (3) @(negedge core_clk);
        senseIn.errEvent = 1'b0;
        senseIn.dataEvent = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask
    // Line energy present or absent
    task automatic setQuiet(input logic q);
        @(negedge core_clk);
        senseIn.noEnergy = q;
    endtask
endmodule
`default_nettype wire

/* File: test/energy_detect_power_control_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module energy_detect_power_control_tb_top;
    import edpc_pkg::*;
    localparam int IDLE = 50;
    logic core_clk;
    logic sys_rst;
    edpc_req_t regReq;
    logic [15:0] rdData;
    edpc_sense_t senseIn;
    logic lineDriverOn;
    logic pulseOut;
    logic [15:0] word;
    int fails;
    int compares;
    int cycles;
    // Short idle timeout keeps the counter-reset case cheap to reach
    energy_detect_power_control #(.IDLE_CYCLES(IDLE)) uut (
        .core_clk(core_clk), .sys_rst(sys_rst), .regReq(regReq), .rdData(rdData),
        .senseIn(senseIn), .lineDriverOn(lineDriverOn), .pulseOut(pulseOut));
    edpc_line_model line (.core_clk(core_clk), .senseIn(senseIn), .pulseOut(pulseOut));
    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One strobe cycle, then a full cycle so the registered answer has landed
    task automatic regAccess(input logic wr, input logic [4:0] a, input logic [15:0] d);
        @(negedge core_clk);
        regReq = '{wrEn: wr, rdEn: ~wr, addr: a, wrData: d};
        @(negedge core_clk);
        regReq = '0;
        @(negedge core_clk);
    endtask
    task automatic regRead(output logic [15:0] v);
        regAccess(1'b0, 5'h1D, 16'h0000);
        v = rdData;
    endtask
    // Sleep, idle past the timeout, then wake on a data threshold of 2
    task automatic wakeCycle(input int expPulses);
        int base;
        line.setQuiet(1'b1);
        repeat (IDLE + 20) @(negedge core_clk);
        check(16'(lineDriverOn), 16'h0000);
        line.setQuiet(1'b0);
        line.lineEvent(1'b0);
        repeat (IDLE + 20) @(negedge core_clk);
        // Snapshot instead of clearing, so only the model writes its counter
        base = line.pulseCount;
        line.lineEvent(1'b0);
        check(16'(lineDriverOn), 16'h0000);
        line.lineEvent(1'b0);
        repeat (20) @(negedge core_clk);
        check(16'(lineDriverOn), 16'h0001);
        check(16'(line.pulseCount - base), 16'(expPulses));
    endtask
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Hang guard, well above the roughly 460 cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            results();
        end
    end
    initial begin
        sys_rst = 1'b1;
        regReq = '0;
        fails = 0;
        compares = 0;
        cycles = 0;
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        // Disabled: quiet line and events must change nothing
        line.setQuiet(1'b1);
        line.lineEvent(1'b0);
        check(16'(lineDriverOn), 16'h0001);
        regRead(word);
        check(word & 16'hFBFF, 16'h6011);
        regAccess(1'b1, 5'h1C, 16'hFFFF);
        regAccess(1'b0, 5'h1C, 16'h0000);
        // Unmapped access leaves answer and register alone
        check(rdData, word);
        regRead(word);
        check(word & 16'hFBFF, 16'h6011);
        // Crossover stays the software's business outside this block
        regAccess(1'b1, 5'h1D, 16'hE012);
        wakeCycle(4);
        regRead(word);
        check(word & 16'h0500, 16'h0500);
        regRead(word);
        check(word & 16'h0300, 16'h0000);
        // Error threshold of 2, no effect on power
        regAccess(1'b1, 5'h1D, 16'hE022);
        line.lineEvent(1'b1);
        regRead(word);
        check(word & 16'h0200, 16'h0000);
        line.lineEvent(1'b1);
        regRead(word);
        check(word & 16'h0600, 16'h0600);
        check(16'(lineDriverOn), 16'h0001);
        // Manual toggle down and back up, bit reads back clear
        regAccess(1'b1, 5'h1D, 16'hF012);
        check(16'(lineDriverOn), 16'h0000);
        regRead(word);
        check(word & 16'h1400, 16'h0000);
        regAccess(1'b1, 5'h1D, 16'hF012);
        check(16'(lineDriverOn), 16'h0001);
        regAccess(1'b1, 5'h1D, 16'hE812);
        wakeCycle(1);
        // Disable while the line is quiet: driver must stay on
        regAccess(1'b1, 5'h1D, 16'h6012);
        line.setQuiet(1'b1);
        repeat (20) @(negedge core_clk);
        check(16'(lineDriverOn), 16'h0001);
        results();
    end
endmodule
`default_nettype wire
